/* File: timer_pkg.sv */
/*
  Constants, field layouts and carrier types for the 16-bit timer channel.
  Assumes a single clock domain at 20 MHz and a 32-bit classic Wishbone slave.
*/
// Notes on behaviour
// - counter is a 16-bit binary up-counter, one step per selected count tick
// - two-bit select picks divide-by-1, 4, 16 tick or the external count pin
// - run at 1 counts; run at 0 stops and holds the count at zero
// - clear-on-match at 1 zeroes count on period match; at 0 it wraps freely
// - counter overflow past its maximum raises the timer interrupt
// - two compare registers; match flag while running and count equals either one
// - each compare register has a buffer; buffering is off after reset
// - buffer-enable bit at 0 disables buffering, at 1 enables it
// - with buffering on, buffers load both compares on period match
// - while stopped, compare writes take effect at once even with buffering
// - capture timing field selects when count latches into both captures
// - writing 0 to the soft capture bit copies count into capture a
// - live snapshot read returns the current count, apart from captures
// - a compare match raises the timer interrupt
// - each capture register has its own interrupt on latching
package timer_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADR_RUN = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_CMP_A = 8'h0c;
  localparam logic [7:0] ADR_PERIOD = 8'h10;
  localparam logic [7:0] ADR_CAP_A = 8'h14;
  localparam logic [7:0] ADR_CAP_B = 8'h18;
  localparam logic [7:0] ADR_LIVE = 8'h1c;
  localparam logic [7:0] ADR_STATUS = 8'h20;
  localparam logic [7:0] ADR_MASK = 8'h24;
  localparam logic [7:0] ADR_CLKCFG = 8'h28;
  // ==========================================================
  // field positions and widths
  localparam int RUN_BIT = 0;
  localparam int DBUF_BIT = 0;
  localparam int SOFT_CAP_BIT = 5;
  localparam int MODE_W = 6;
  localparam int CLKCFG_W = 7;
  localparam int IRQ_CMP_A = 0;
  localparam int IRQ_PERIOD = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_CAP_A = 3;
  localparam int IRQ_CAP_B = 4;
  localparam int IRQ_W = 5;
  localparam int PRE_W = 16;
  // ==========================================================
  // reset values and encodings
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;
  localparam logic [2:0] GEAR_FC = 3'h0;
  localparam logic [2:0] GEAR_DIV2 = 3'h4;
  localparam logic [2:0] GEAR_DIV4 = 3'h5;
  localparam logic [2:0] GEAR_DIV8 = 3'h6;
  localparam logic SRC_OSC = 1'b1;
  // ==========================================================
  // carrier types
  typedef enum logic [1:0] {SEL_T1, SEL_T4, SEL_T16, SEL_EXT} clk_sel_t;
  typedef enum logic [1:0] {CAP_OFF, CAP_EXT_EDGES, CAP_EXT_PERIOD, CAP_MATCHES} cap_mode_t;
  typedef struct packed {
    logic soft_capture_trigger;
    cap_mode_t capture_timing_select;
    logic clear_on_period_match;
    clk_sel_t count_clock_select;
  } timer_mode_t;
  typedef struct packed {
    logic osc_src;
    logic [2:0] gear;
    logic [2:0] prescale;
  } clock_config_t;
  localparam timer_mode_t MODE_RST = 6'h20;
  localparam clock_config_t CLKCFG_RST = 7'h00;
endpackage : timer_pkg

/* File: timer_prescaler.sv */
/*
  Prescaler producing the divide-by-1, 4 and 16 count ticks.
  Assumes the system clock is the oscillator fc and the gear is stable while counting.
*/
`timescale 1ns/1ps
module timer_prescaler
  import timer_pkg::*;
(
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // configuration
  input wire clock_config_t cfg_i,
  // one-cycle tick pulses
  output logic tick1_o,
  output logic tick4_o,
  output logic tick16_o
);
  logic [PRE_W-1:0] pre_r;
  logic [4:0] n1;

  // gear divider expressed as a power of two
  function automatic logic [4:0] gear_shift(input logic [2:0] g);
    case (g)
      GEAR_DIV2: gear_shift = 5'h01;
      GEAR_DIV4: gear_shift = 5'h02;
      GEAR_DIV8: gear_shift = 5'h03;
      default: gear_shift = 5'h00;
    endcase
  endfunction : gear_shift

  // true when the low n bits of the divider are all ones
  function automatic logic at_tick(input logic [PRE_W-1:0] c, input logic [4:0] n);
    logic [PRE_W-1:0] m;
    m = (16'h0001 << n) - 16'h0001;
    at_tick = ((c & m) == m);
  endfunction : at_tick

  // divide-by-1 tick exponent
  assign n1 = (cfg_i.osc_src == SRC_OSC) ? 5'({2'b00, cfg_i.prescale} + 5'h01)
      : 5'(gear_shift(cfg_i.gear) + {2'b00, cfg_i.prescale} + 5'h01);

  // free-running divider and registered ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= '0;
      tick1_o <= 1'b0;
      tick4_o <= 1'b0;
      tick16_o <= 1'b0;
    end else if (ce_i) begin
      pre_r <= pre_r + 16'h0001;
      tick1_o <= at_tick(pre_r, n1);
      tick4_o <= at_tick(pre_r, 5'(n1 + 5'h02));
      tick16_o <= at_tick(pre_r, 5'(n1 + 5'h04));
    end
  end
endmodule : timer_prescaler

/* File: timer_channel.sv */
/*
  Timer channel: up-counter, double-buffered compares, captures, interrupts,
  register file on a classic Wishbone slave.
  Assumes the external count input is synchronous to clk_i.
*/
`timescale 1ns/1ps
module timer_channel
  import timer_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // external pin
  input wire logic external_count_input_i,
  // status outputs
  output logic irq_o,
  output logic match_o,
  output logic timer_interrupt_o,
  output logic capture_interrupt_a_o,
  output logic capture_interrupt_b_o
);
  // ==========================================================
  // state
  logic run_r, dbuf_r, ext_q_r;
  timer_mode_t mode_r;
  clock_config_t clkcfg_r;
  logic [15:0] cnt_r, cmp_a_r, per_r, buf_a_r, buf_p_r, cap_a_r, cap_b_r;
  logic [IRQ_W-1:0] stat_r, mask_r, stat_nxt, ev;
  logic tick1, tick4, tick16, tick_sel, cnt_tick;
  logic a_hit, p_hit, ovf_hit, cap_a_ev, cap_b_ev, soft_cap;
  logic req, wr, rd_load, ext_rise, ext_fall, running_buf;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  timer_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cfg_i(clkcfg_r),
    .tick1_o(tick1),
    .tick4_o(tick4),
    .tick16_o(tick16)
  );

  // ==========================================================
  // bus decode: ack one cycle after request, write at ack edge
  assign req = cyc_i & stb_i;
  assign wr = req & we_i & ack_o;
  assign rd_load = req & ~we_i & ~ack_o;
  assign soft_cap = wr & (adr_i == ADR_MODE) & sel_i[0] & ~dat_i[SOFT_CAP_BIT];
  assign running_buf = dbuf_r & run_r;

  // ==========================================================
  // count tick selection and hit detection
  assign ext_rise = external_count_input_i & ~ext_q_r;
  assign ext_fall = ~external_count_input_i & ext_q_r;
  always_comb begin
    case (mode_r.count_clock_select)
      SEL_T1: tick_sel = tick1;
      SEL_T4: tick_sel = tick4;
      SEL_T16: tick_sel = tick16;
      SEL_EXT: tick_sel = ext_rise;
      default: tick_sel = 1'b0;
    endcase
  end
  assign cnt_tick = run_r & tick_sel;
  assign a_hit = cnt_tick & (cnt_r == cmp_a_r);
  assign p_hit = cnt_tick & (cnt_r == per_r);
  assign ovf_hit = cnt_tick & (cnt_r == COUNT_MAX);

  // hardware capture moments
  always_comb begin
    case (mode_r.capture_timing_select)
      CAP_EXT_EDGES: begin
        cap_a_ev = ext_rise & run_r;
        cap_b_ev = ext_fall & run_r;
      end
      CAP_EXT_PERIOD: begin
        cap_a_ev = ext_rise & run_r;
        cap_b_ev = p_hit;
      end
      CAP_MATCHES: begin
        cap_a_ev = a_hit;
        cap_b_ev = p_hit;
      end
      default: begin
        cap_a_ev = 1'b0;
        cap_b_ev = 1'b0;
      end
    endcase
  end

  // sticky status: read clears, a same-cycle event wins
  assign ev = {cap_b_ev, cap_a_ev | soft_cap, ovf_hit, p_hit, a_hit};
  assign stat_nxt = ((rd_load && adr_i == ADR_STATUS) ? '0 : stat_r) | ev;

  // ==========================================================
  // up-counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= WORD_RST;
      ext_q_r <= 1'b0;
    end else if (ce_i) begin
      ext_q_r <= external_count_input_i;
      if (!run_r) begin
        cnt_r <= WORD_RST;
      end else if (cnt_tick) begin
        if (mode_r.clear_on_period_match && cnt_r == per_r) begin
          cnt_r <= WORD_RST;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
      dbuf_r <= 1'b0;
      mode_r <= MODE_RST;
      clkcfg_r <= CLKCFG_RST;
      mask_r <= MASK_RST;
    end else if (ce_i && wr) begin
      case (adr_i)
        ADR_RUN: if (sel_i[0]) run_r <= dat_i[RUN_BIT];
        ADR_CTRL: if (sel_i[0]) dbuf_r <= dat_i[DBUF_BIT];
        ADR_MODE: if (sel_i[0]) mode_r <= timer_mode_t'({1'b1, dat_i[MODE_W-2:0]});
        ADR_CLKCFG: if (sel_i[0]) clkcfg_r <= clock_config_t'(dat_i[CLKCFG_W-1:0]);
        ADR_MASK: if (sel_i[0]) mask_r <= dat_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // compare registers and their buffers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_a_r <= WORD_RST;
      per_r <= WORD_RST;
      buf_a_r <= WORD_RST;
      buf_p_r <= WORD_RST;
    end else if (ce_i) begin
      if (wr && adr_i == ADR_CMP_A) begin
        buf_a_r <= merge(buf_a_r, dat_i, sel_i);
        if (!running_buf) cmp_a_r <= merge(buf_a_r, dat_i, sel_i);
      end else if (dbuf_r && p_hit) begin
        cmp_a_r <= buf_a_r;
      end
      if (wr && adr_i == ADR_PERIOD) begin
        buf_p_r <= merge(buf_p_r, dat_i, sel_i);
        if (!running_buf) per_r <= merge(buf_p_r, dat_i, sel_i);
      end else if (dbuf_r && p_hit) begin
        per_r <= buf_p_r;
      end
    end
  end

  // capture registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_a_r <= WORD_RST;
      cap_b_r <= WORD_RST;
    end else if (ce_i) begin
      if (soft_cap || cap_a_ev) cap_a_r <= cnt_r;
      if (cap_b_ev) cap_b_r <= cnt_r;
    end
  end

  // status, interrupt and match outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
      irq_o <= 1'b0;
      match_o <= 1'b0;
      timer_interrupt_o <= 1'b0;
      capture_interrupt_a_o <= 1'b0;
      capture_interrupt_b_o <= 1'b0;
    end else if (ce_i) begin
      stat_r <= stat_nxt;
      irq_o <= |(stat_nxt & mask_r);
      match_o <= run_r & ((cnt_r == cmp_a_r) | (cnt_r == per_r));
      timer_interrupt_o <= a_hit | p_hit | ovf_hit;
      capture_interrupt_a_o <= ev[IRQ_CAP_A];
      capture_interrupt_b_o <= ev[IRQ_CAP_B];
    end
  end

  // bus answer and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else if (ce_i) begin
      ack_o <= req & ~ack_o;
      if (rd_load) begin
        case (adr_i)
          ADR_RUN: dat_o <= {31'h0, run_r};
          ADR_MODE: dat_o <= {26'h0, mode_r};
          ADR_CTRL: dat_o <= {31'h0, dbuf_r};
          ADR_CMP_A: dat_o <= {16'h0, cmp_a_r};
          ADR_PERIOD: dat_o <= {16'h0, per_r};
          ADR_CAP_A: dat_o <= {16'h0, cap_a_r};
          ADR_CAP_B: dat_o <= {16'h0, cap_b_r};
          ADR_LIVE: dat_o <= {16'h0, cnt_r};
          ADR_STATUS: dat_o <= {27'h0, stat_r};
          ADR_MASK: dat_o <= {27'h0, mask_r};
          ADR_CLKCFG: dat_o <= {25'h0, clkcfg_r};
          default: dat_o <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // steps of a stopped compare write and of a soft capture
  sequence stopped_write_a;
    ce_i && wr && adr_i == ADR_CMP_A && sel_i == 4'hf && !run_r;
  endsequence
  sequence soft_capture_req;
    ce_i && soft_cap;
  endsequence
  // status register read, and the cycles without one
  sequence status_read;
    ce_i && rd_load && adr_i == ADR_STATUS;
  endsequence
  sequence status_kept;
    ce_i && !(rd_load && adr_i == ADR_STATUS);
  endsequence

  // counter, compare and buffer checks
  AST_STOP_ZERO: assert property (ce_i && !run_r |=> cnt_r == 16'h0000)
    else $error("counter not zero while stopped");
  AST_COUNT_STEP: assert property (ce_i && cnt_tick && !(mode_r.clear_on_period_match
      && cnt_r == per_r) |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
    else $error("counter did not step by one");
  AST_CLEAR_MATCH: assert property (ce_i && cnt_tick && mode_r.clear_on_period_match
      && cnt_r == per_r |=> cnt_r == 16'h0000)
    else $error("counter not cleared on period match");
  AST_OVF_IRQ: assert property (ce_i && cnt_tick && cnt_r == 16'hffff
      |=> timer_interrupt_o && stat_r[IRQ_OVF])
    else $error("overflow did not raise interrupt");
  AST_MATCH_LEVEL: assert property (ce_i && run_r && (cnt_r == cmp_a_r || cnt_r == per_r)
      |=> match_o)
    else $error("match flag missing");
  AST_MATCH_DROP: assert property (ce_i && !run_r |=> !match_o)
    else $error("match flag set while stopped");
  AST_EXT_HOLD: assert property (ce_i && run_r && mode_r.count_clock_select == SEL_EXT
      && !ext_rise |=> cnt_r == $past(cnt_r))
    else $error("count moved without a pin edge");
  AST_DBUF_XFER: assert property (ce_i && dbuf_r && p_hit && !wr
      |=> cmp_a_r == $past(buf_a_r) && per_r == $past(buf_p_r))
    else $error("buffers not transferred on period match");
  AST_STOPPED_WRITE: assert property (stopped_write_a |=> cmp_a_r == $past(dat_i[15:0]))
    else $error("stopped compare write not immediate");
  AST_RUN_BUFFERED: assert property (ce_i && wr && adr_i == ADR_CMP_A && running_buf
      && !p_hit |=> cmp_a_r == $past(cmp_a_r))
    else $error("buffered write reached compare early");

  // capture, status and interrupt checks
  AST_SOFT_CAPTURE: assert property (soft_capture_req
      |=> cap_a_r == $past(cnt_r) ##0 capture_interrupt_a_o)
    else $error("soft capture did not latch count");
  AST_CAP_A_IRQ: assert property (ce_i && cap_a_ev |=> capture_interrupt_a_o
      && cap_a_r == $past(cnt_r))
    else $error("capture a not latched with interrupt");
  AST_CAP_B_IRQ: assert property (ce_i && cap_b_ev |=> capture_interrupt_b_o
      && cap_b_r == $past(cnt_r))
    else $error("capture b not latched with interrupt");
  AST_TIMER_PULSE: assert property (ce_i && (a_hit || p_hit) |=> timer_interrupt_o)
    else $error("compare hit did not raise interrupt");
  AST_READ_CLEAR: assert property (status_read |=> stat_r == $past(ev))
    else $error("status read did not clear");
  AST_STATUS_STICKY: assert property (status_kept |=> (stat_r & $past(stat_r)) == $past(stat_r))
    else $error("status bit lost without a read");
  AST_IRQ_LEVEL: assert property (ce_i |=> irq_o == |(stat_r & $past(mask_r)))
    else $error("interrupt level disagrees with status and mask");

  // bus answer check
  AST_WB_ACK: assert property (ce_i && req && !ack_o ##1 ce_i |-> ack_o ##1 (!ce_i || !ack_o))
    else $error("wishbone answer not a single cycle");
endmodule : timer_channel

/* File: timer_upcounter_compare_capture_bench.sv */
/*
  Self-checking bench for the timer channel: bus access, tick rates, counting,
  captures, period clear, interrupts and compare double buffering.
  Assumes timer_pkg, timer_prescaler and timer_channel are compiled first.
*/
`timescale 1ns/1ps
module timer_upcounter_compare_capture_bench;
  import timer_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic external_count_input_i = 1'b0;
  logic irq_o;
  logic match_o;
  logic timer_interrupt_o;
  logic capture_interrupt_a_o;
  logic capture_interrupt_b_o;
  int failures = 0;
  int compares = 0;
  int tint_n = 0;
  int capa_n = 0;
  int capb_n = 0;

  // clock: 50 ns period
  always #25 clk_i = ~clk_i;

  timer_channel u_timer_channel (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .external_count_input_i(external_count_input_i),
    .irq_o(irq_o), .match_o(match_o), .timer_interrupt_o(timer_interrupt_o),
    .capture_interrupt_a_o(capture_interrupt_a_o),
    .capture_interrupt_b_o(capture_interrupt_b_o)
  );

  // count interrupt pulses
  always @(posedge clk_i) begin
    if (timer_interrupt_o === 1'b1) tint_n++;
    if (capture_interrupt_a_o === 1'b1) capa_n++;
    if (capture_interrupt_b_o === 1'b1) capb_n++;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    check("bus ack", {31'h0, ack_o}, 32'h1);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask : rd

  // rising edges on the external count pin, then settle
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      external_count_input_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      external_count_input_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask : pulses

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // scenarios
  task automatic test_reset();
    logic [7:0] adrs [10] = '{ADR_RUN, ADR_CTRL, ADR_CMP_A, ADR_PERIOD, ADR_CAP_A,
                              ADR_CAP_B, ADR_LIVE, ADR_STATUS, ADR_MASK, ADR_CLKCFG};
    foreach (adrs[i]) rd(adrs[i], 32'h0, $sformatf("reset value %h", adrs[i]));
    rd(ADR_MODE, 32'h20, "mode reset");
    wr(8'h2c, 32'hffff);
    rd(8'h2c, 32'h0, "unmapped read");
    wr(ADR_LIVE, 32'h1234);
    rd(ADR_LIVE, 32'h0, "snapshot read only");
    $display("test reset done");
  endtask : test_reset

  // internal ticks: divide-by-1, 4 and 16 from prescale code 1
  task automatic test_ticks();
    logic [31:0] q;
    wr(ADR_CLKCFG, 32'h41);
    for (int s = 0; s < 3; s++) begin
      wr(ADR_MODE, 32'h20 | s);
      wr(ADR_RUN, 32'h1);
      repeat (10 << (2 * s + 2)) @(posedge clk_i);
      wb(1'b0, ADR_LIVE, 32'h0, q);
      check($sformatf("ticks sel %0d", s), {31'h0, q >= 9 && q <= 11}, 32'h1);
      wr(ADR_RUN, 32'h0);
      rd(ADR_LIVE, 32'h0, "stopped count");
    end
    $display("test ticks done");
  endtask : test_ticks

  // external counting, live read, soft capture, stop clears
  task automatic test_soft_capture();
    wr(ADR_MODE, 32'h23);
    wr(ADR_RUN, 32'h1);
    pulses(7);
    rd(ADR_LIVE, 32'h7, "live count");
    // pin edges while the enable is low must not count
    @(posedge clk_i);
    ce_i <= 1'b0;
    pulses(2);
    ce_i <= 1'b1;
    rd(ADR_LIVE, 32'h7, "frozen by enable");
    capa_n = 0;
    wr(ADR_MODE, 32'h03);
    repeat (3) @(posedge clk_i);
    rd(ADR_CAP_A, 32'h7, "soft capture");
    check("capture a pulses", capa_n, 32'h1);
    wr(ADR_RUN, 32'h0);
    rd(ADR_LIVE, 32'h0, "cleared on stop");
    $display("test soft capture done");
  endtask : test_soft_capture

  // pin edge capture modes: rise and fall, then rise and period hit
  task automatic test_capture_modes();
    wr(ADR_MODE, 32'h2b);
    wr(ADR_RUN, 32'h1);
    pulses(3);
    rd(ADR_CAP_A, 32'h2, "capture on rise");
    rd(ADR_CAP_B, 32'h3, "capture on fall");
    wr(ADR_RUN, 32'h0);
    wr(ADR_PERIOD, 32'h4);
    wr(ADR_MODE, 32'h37);
    wr(ADR_RUN, 32'h1);
    pulses(7);
    rd(ADR_CAP_A, 32'h1, "rise with period");
    rd(ADR_CAP_B, 32'h4, "capture on period only");
    wr(ADR_RUN, 32'h0);
    $display("test capture modes done");
  endtask : test_capture_modes

  // clear on period match, compare match flag and interrupts
  task automatic test_clear_match();
    logic [31:0] q;
    wr(ADR_MASK, 32'h02);
    wr(ADR_MODE, 32'h27);
    wr(ADR_PERIOD, 32'h3);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    wr(ADR_RUN, 32'h1);
    repeat (3) @(posedge clk_i);
    check("match flag", {31'h0, match_o}, 32'h1);
    tint_n = 0;
    pulses(4);
    rd(ADR_LIVE, 32'h0, "period clear");
    check("irq level", {31'h0, irq_o}, 32'h1);
    check("timer pulses", tint_n, 32'h2);
    rd(ADR_STATUS, 32'h03, "status hits");
    repeat (2) @(posedge clk_i);
    check("irq after clear", {31'h0, irq_o}, 32'h0);
    rd(ADR_STATUS, 32'h0, "status cleared");
    wr(ADR_RUN, 32'h0);
    wr(ADR_MASK, 32'h0);
    $display("test clear match done");
  endtask : test_clear_match

  // buffered compares, hardware capture on compare and period hits
  task automatic test_double_buffer();
    logic [31:0] q;
    wr(ADR_CTRL, 32'h1);
    wr(ADR_MODE, 32'h3f);
    wr(ADR_PERIOD, 32'ha);
    wr(ADR_CMP_A, 32'h2);
    wb(1'b0, ADR_STATUS, 32'h0, q);
    wr(ADR_RUN, 32'h1);
    wr(ADR_CMP_A, 32'h6);
    capb_n = 0;
    pulses(3);
    rd(ADR_STATUS, 32'h09, "old compare hit");
    rd(ADR_CAP_A, 32'h2, "capture on compare");
    pulses(8);
    rd(ADR_STATUS, 32'h12, "period hit");
    rd(ADR_CAP_B, 32'ha, "capture on period");
    check("capture b pulses", capb_n, 32'h1);
    pulses(3);
    rd(ADR_STATUS, 32'h0, "old compare gone");
    pulses(4);
    rd(ADR_STATUS, 32'h09, "new compare hit");
    rd(ADR_CAP_A, 32'h6, "capture new compare");
    wr(ADR_RUN, 32'h0);
    wr(ADR_CTRL, 32'h0);
    $display("test double buffer done");
  endtask : test_double_buffer

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_ticks();
    test_soft_capture();
    test_capture_modes();
    test_clear_match();
    test_double_buffer();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    $display("mismatch watchdog expected done seen hang");
    failures++;
    tally_and_finish();
  end
endmodule : timer_upcounter_compare_capture_bench
